// ===== rtl/asp_pkg.sv
// shared constants and types for the asynchronous serial port
package asp_pkg;

   // ***************************************************
   // modes, states and carriers
   // ***************************************************
   localparam logic [1:0] MODE_SHIFT = 2'h0;   // shift-register mode, not handled here
   localparam logic [1:0] MODE_8BIT = 2'h1;    // 10-bit frame, timer-paced
   localparam logic [1:0] MODE_9FIX = 2'h2;    // 11-bit frame, clock-paced
   localparam logic [1:0] MODE_9VAR = 2'h3;    // 11-bit frame, timer-paced

   typedef enum logic [1:0] {
      TX_IDLE  = 2'b00,
      TX_WAIT  = 2'b01,
      TX_START = 2'b10,
      TX_DATA  = 2'b11
   } asp_tx_state_t;

   typedef enum logic [1:0] {
      RX_HUNT = 2'b00,
      RX_BITS = 2'b01,
      RX_TAIL = 2'b10
   } asp_rx_state_t;

   typedef struct packed {
      logic [1:0] mode;                 // frame mode
      logic double_rate;                // selects the faster bit rate
      logic multiprocessor_filter;      // drop frames with ninth or stop bit low
      logic rx_enable;                  // reception enable
      logic transmit_ninth_bit;         // ninth bit sent in 9-bit modes
   } asp_ctrl_t;

   typedef struct packed {
      logic receive_done_flag;
      logic transmit_done_flag;
      logic received_ninth_bit;
   } asp_status_t;

   // ***************************************************
   // counts and reset values
   // ***************************************************
   localparam logic [3:0] DIV_LAST = 4'hF;     // last state of the divide-by-16 counter
   localparam logic [3:0] DIV_RESET = 4'h0;
   localparam logic [3:0] SAMPLE_A = 4'h7;     // three sample points per bit time
   localparam logic [3:0] SAMPLE_B = 4'h8;
   localparam logic [3:0] SAMPLE_C = 4'h9;
   localparam logic [8:0] RX_SR_INIT = 9'h1FF;
   localparam logic [8:0] TX_SR_RESET = 9'h000;
   localparam logic [7:0] BUF_RESET = 8'h00;
   localparam logic [2:0] SYNC_RESET = 3'h7;   // line idles high
   localparam logic TX_MARKER = 1'b1;          // ninth position in the 8-bit mode

endpackage

// ===== rtl/asp_uart.sv
// asynchronous serial port, 8-bit and 9-bit frame modes
//
// Notes on behaviour
// - 8-bit mode: start, eight data LSB-first, stop
// - 8-bit mode: stop bit goes to ninth flag
// - 8-bit mode rate from timer overflow
// - buffer write loads marker one (8-bit) or the ninth bit (9-bit), requests transmit
// - sending starts after next counter rollover
// - start bit, then data, then first shift
// - 8-bit: final shift, done at tenth rollover
// - start on falling edge, sixteen samples per bit
// - start edge resets counter, loads all ones
// - majority vote of samples seven, eight, nine
// - false start bit returns to hunting
// - 8-bit: load only if done clear, filter ok
// - failed frame discarded, then hunt again
// - 9-bit modes: ninth bit sent and received
// - mode 2 fixed rate, mode 3 timer rate
// - 9-bit: first shift clocks stop one in
// - 9-bit: final shift, done at eleventh rollover
// - 9-bit: load data and ninth bit, filtered
// - 9-bit: hunt again one bit later
// - receive only while enable is set, but a final sample in the cycle the enable clears still loads
// - transmit done set at stop, sticky
// - receive done set mid-stop (8-bit) or mid-ninth-bit (9-bit), sticky
`timescale 1ns/1ps

module asp_uart (
   input wire logic clk,                         // core clock
   input wire logic rst_n,                       // async reset, active low
   input wire asp_pkg::asp_ctrl_t ctrl,          // software control bits
   input wire logic timer_overflow,              // one-cycle overflow pulse of the rate timer
   input wire logic buf_write,                   // one-cycle write strobe to the data buffer
   input wire logic [7:0] buf_write_data,        // byte to transmit
   input wire logic transmit_done_clear,         // one-cycle clear of the transmit flag
   input wire logic receive_done_clear,          // one-cycle clear of the receive flag
   input wire logic rxd,                         // receive pin, asynchronous
   output logic txd,                             // transmit pin
   output logic [7:0] serial_data_buffer,        // last accepted byte
   output asp_pkg::asp_status_t status           // done flags and received ninth bit
);

   // ***************************************************
   // pin synchroniser and rate tick
   // ***************************************************
   logic [2:0] sync_ff, nxt_sync;
   logic rx_level_ff, nxt_rx_level;
   logic half_ff, nxt_half;
   logic tick;

   // the half-rate toggle skips every second tick unless the double rate is chosen
   function automatic logic rate_gate(input logic dbl, input logic half);
      rate_gate = dbl | half;
   endfunction

   // divider step; wraps from fifteen to zero on its own, which is the rollover
   function automatic logic [3:0] div_step(input logic [3:0] cnt);
      div_step = cnt + 4'h1;
   endfunction

   // the level only moves once the second and third stages agree
   always_comb begin
      nxt_sync = {sync_ff[1:0], rxd};
      nxt_rx_level = (sync_ff[1] == sync_ff[2]) ? sync_ff[2] : rx_level_ff;
      nxt_half = half_ff;
      tick = 1'b0;
      if (ctrl.mode == asp_pkg::MODE_9FIX) begin
         // fixed rate: sixteen ticks per bit at clk or clk/2
         nxt_half = ~half_ff;
         tick = rate_gate(ctrl.double_rate, half_ff);
      end else if (timer_overflow) begin
         // timer overflows pace the 8-bit and variable modes
         nxt_half = ~half_ff;
         tick = rate_gate(ctrl.double_rate, half_ff);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_ff <= asp_pkg::SYNC_RESET;
         rx_level_ff <= 1'b1;
         half_ff <= 1'b0;
      end else begin
         sync_ff <= nxt_sync;
         rx_level_ff <= nxt_rx_level;
         half_ff <= nxt_half;
      end
   end

   // ***************************************************
   // transmitter
   // ***************************************************
   asp_pkg::asp_tx_state_t tx_state_ff, nxt_tx_state;
   logic [3:0] tx_div_ff, nxt_tx_div;
   logic [8:0] tx_sr_ff, nxt_tx_sr;
   logic tx_first_ff, nxt_tx_first;
   logic txd_ff, nxt_txd;
   logic ti_ff, nxt_ti;
   logic tx_roll, tx_last, tx_fill, async_mode;

   assign async_mode = (ctrl.mode != asp_pkg::MODE_SHIFT);

   // shift register walk: data out on the right, fill on the left
   always_comb begin
      nxt_tx_state = tx_state_ff;
      nxt_tx_sr = tx_sr_ff;
      nxt_tx_first = tx_first_ff;
      nxt_txd = txd_ff;
      nxt_ti = ti_ff;
      // bit times follow the free-running divider, not the buffer write
      nxt_tx_div = tick ? div_step(tx_div_ff) : tx_div_ff;
      tx_roll = tick && (tx_div_ff == asp_pkg::DIV_LAST);
      // marker or stop one just left of the output bit, zeros beyond
      tx_last = !tx_first_ff && (tx_sr_ff[8:2] == 7'h00) && tx_sr_ff[1];
      // 9-bit modes clock the stop one in on the first shift only
      tx_fill = tx_first_ff && (ctrl.mode != asp_pkg::MODE_8BIT);
      case (tx_state_ff)
         asp_pkg::TX_IDLE: begin
            nxt_txd = 1'b1;
         end
         asp_pkg::TX_WAIT: begin
            if (tx_roll) begin
               nxt_tx_state = asp_pkg::TX_START;
               nxt_txd = 1'b0;                    // start bit
            end
         end
         asp_pkg::TX_START: begin
            if (tx_roll) begin
               nxt_tx_state = asp_pkg::TX_DATA;
               nxt_txd = tx_sr_ff[0];             // output bit enabled
            end
         end
         asp_pkg::TX_DATA: begin
            if (tx_roll) begin
               nxt_tx_sr = {tx_fill, tx_sr_ff[8:1]};
               nxt_tx_first = 1'b0;
               if (tx_last) begin
                  // final shift: send drops, line shows the stop bit
                  nxt_tx_state = asp_pkg::TX_IDLE;
                  nxt_txd = 1'b1;
                  nxt_ti = 1'b1;                  // flag at start of stop bit
               end else begin
                  nxt_txd = tx_sr_ff[1];          // LSB first
               end
            end
         end
         default: begin
            nxt_tx_state = asp_pkg::TX_IDLE;
            nxt_txd = 1'b1;
         end
      endcase
      if (buf_write && async_mode) begin
         // marker one or the programmed ninth bit goes in position nine
         nxt_tx_sr = {(ctrl.mode == asp_pkg::MODE_8BIT) ? asp_pkg::TX_MARKER
                      : ctrl.transmit_ninth_bit, buf_write_data};
         nxt_tx_first = 1'b1;
         nxt_tx_state = asp_pkg::TX_WAIT;
         nxt_txd = 1'b1;
      end
      // a set in the same cycle as a clear wins
      if (transmit_done_clear && !(nxt_ti && !ti_ff)) begin
         nxt_ti = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_state_ff <= asp_pkg::TX_IDLE;
         tx_div_ff <= asp_pkg::DIV_RESET;
         tx_sr_ff <= asp_pkg::TX_SR_RESET;
         tx_first_ff <= 1'b0;
         txd_ff <= 1'b1;                          // idle high after reset
         ti_ff <= 1'b0;
      end else begin
         tx_state_ff <= nxt_tx_state;
         tx_div_ff <= nxt_tx_div;
         tx_sr_ff <= nxt_tx_sr;
         tx_first_ff <= nxt_tx_first;
         txd_ff <= nxt_txd;
         ti_ff <= nxt_ti;
      end
   end

   // ***************************************************
   // receiver
   // ***************************************************
   asp_pkg::asp_rx_state_t rx_state_ff, nxt_rx_state;
   logic [3:0] rx_div_ff, nxt_rx_div;
   logic [8:0] rx_sr_ff, nxt_rx_sr;
   logic [1:0] samp_ff, nxt_samp;
   logic prev_level_ff, nxt_prev_level;
   logic [7:0] rx_buf_ff, nxt_rx_buf;
   logic rb8_ff, nxt_rb8;
   logic ri_ff, nxt_ri;
   logic vote, accept;

   // majority of three, shared by every bit time
   function automatic logic majority(input logic a, input logic b, input logic c);
      majority = (a & b) | (a & c) | (b & c);
   endfunction

   always_comb begin
      nxt_rx_state = rx_state_ff;
      nxt_rx_div = rx_div_ff;
      nxt_rx_sr = rx_sr_ff;
      nxt_samp = samp_ff;
      nxt_prev_level = prev_level_ff;
      nxt_rx_buf = rx_buf_ff;
      nxt_rb8 = rb8_ff;
      nxt_ri = ri_ff;
      vote = majority(samp_ff[1], samp_ff[0], rx_level_ff);
      // filter looks at the stop bit in 8-bit mode, ninth bit otherwise
      accept = !ri_ff && (!ctrl.multiprocessor_filter || vote);
      if (tick) begin
         nxt_prev_level = rx_level_ff;
         nxt_rx_div = div_step(rx_div_ff);
      end
      case (rx_state_ff)
         asp_pkg::RX_HUNT: begin
            // line checked at sixteen times the bit rate
            if (tick && ctrl.rx_enable && async_mode && prev_level_ff && !rx_level_ff) begin
               nxt_rx_state = asp_pkg::RX_BITS;
               nxt_rx_div = asp_pkg::DIV_RESET;   // align rollovers to the bit edges
               nxt_rx_sr = asp_pkg::RX_SR_INIT;
            end
         end
         asp_pkg::RX_BITS: begin
            if (tick && rx_div_ff == asp_pkg::SAMPLE_A) begin
               nxt_samp[1] = rx_level_ff;
            end
            if (tick && rx_div_ff == asp_pkg::SAMPLE_B) begin
               nxt_samp[0] = rx_level_ff;
            end
            if (tick && rx_div_ff == asp_pkg::SAMPLE_C) begin
               if (rx_sr_ff == asp_pkg::RX_SR_INIT && vote) begin
                  nxt_rx_state = asp_pkg::RX_HUNT;   // false start rejected
               end else if (!rx_sr_ff[0]) begin
                  // start bit at the far end: final shift
                  nxt_rx_sr = {vote, rx_sr_ff[8:1]};
                  if (accept) begin
                     nxt_rx_buf = rx_sr_ff[8:1];
                     nxt_rb8 = vote;                 // stop or ninth bit
                     nxt_ri = 1'b1;                  // mid stop bit in 8-bit mode, mid ninth bit in 9-bit modes
                  end
                  // 8-bit mode hunts at once, 9-bit modes a bit time later
                  if (ctrl.mode == asp_pkg::MODE_8BIT) begin
                     nxt_rx_state = asp_pkg::RX_HUNT;
                  end else begin
                     nxt_rx_state = asp_pkg::RX_TAIL;
                  end
               end else begin
                  nxt_rx_sr = {vote, rx_sr_ff[8:1]};   // start and data enter
               end
            end
         end
         asp_pkg::RX_TAIL: begin
            if (tick && rx_div_ff == asp_pkg::SAMPLE_C) begin
               nxt_rx_state = asp_pkg::RX_HUNT;
            end
         end
         default: begin
            nxt_rx_state = asp_pkg::RX_HUNT;
         end
      endcase
      // clearing the enable abandons a frame in progress, unless its final sample falls in that same cycle
      if (!ctrl.rx_enable || !async_mode) begin
         nxt_rx_state = asp_pkg::RX_HUNT;
      end
      // a set in the same cycle as a clear wins
      if (receive_done_clear && !(nxt_ri && !ri_ff)) begin
         nxt_ri = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_state_ff <= asp_pkg::RX_HUNT;
         rx_div_ff <= asp_pkg::DIV_RESET;
         rx_sr_ff <= asp_pkg::RX_SR_INIT;
         samp_ff <= 2'h3;
         prev_level_ff <= 1'b1;
         rx_buf_ff <= asp_pkg::BUF_RESET;
         rb8_ff <= 1'b0;
         ri_ff <= 1'b0;
      end else begin
         rx_state_ff <= nxt_rx_state;
         rx_div_ff <= nxt_rx_div;
         rx_sr_ff <= nxt_rx_sr;
         samp_ff <= nxt_samp;
         prev_level_ff <= nxt_prev_level;
         rx_buf_ff <= nxt_rx_buf;
         rb8_ff <= nxt_rb8;
         ri_ff <= nxt_ri;
      end
   end

   // ***************************************************
   // outputs, all from flip-flops
   // ***************************************************
   assign txd = txd_ff;
   assign serial_data_buffer = rx_buf_ff;
   assign status = '{receive_done_flag: ri_ff, transmit_done_flag: ti_ff,
                     received_ninth_bit: rb8_ff};

endmodule

// ===== dv/asp_far_end.sv
// far-end serial device: drives the receive line, reads the transmit line
`timescale 1ns/1ps
module asp_far_end (
   input wire logic clk, // core clock
   input wire logic txd, // line from the port
   output logic rxd // line into the port
);
   // the line idles at the mark level between frames
   initial rxd = 1'b1;
   // n bits LSB first, bt clocks each; called just after an edge
   task automatic send(input logic [10:0] bits, input int n, input int bt);
      for (int i = 0; i < n; i++) begin
         rxd = bits[i];
         repeat (bt) @(posedge clk);
         #1;
      end
      // a full idle bit time keeps back-to-back frames from merging into one low run
      rxd = 1'b1;
      repeat (bt) @(posedge clk);
      #1;
   endtask
   // waits a bounded time for a start bit, then samples each bit mid-way
   task automatic recv(output logic [10:0] bits, input int n, input int bt, output bit ok);
      int w;
      bits = '0;
      w = 0;
      while (txd !== 1'b0 && w < 400) begin
         @(posedge clk);
         #1;
         w++;
      end
      ok = (w < 400);
      repeat (bt / 2) @(posedge clk);
      #1;
      for (int i = 0; i < n; i++) begin
         bits[i] = txd;
         if (i < n - 1) begin
            repeat (bt) @(posedge clk);
            #1;
         end
      end
   endtask
endmodule

// ===== dv/asp_uart_checker.sv
// concurrent checks on the serial port pins and flags
`timescale 1ns/1ps
module asp_uart_checker (
   input wire logic clk, // core clock
   input wire logic rst_n, // async reset
   input wire asp_pkg::asp_ctrl_t ctrl, // control bits
   input wire logic timer_overflow, // rate timer pulse
   input wire logic buf_write, // write strobe
   input wire logic [7:0] buf_write_data, // byte written
   input wire logic transmit_done_clear, // flag clear
   input wire logic receive_done_clear, // flag clear
   input wire logic rxd, // serial in
   input wire logic txd, // serial out
   input wire logic [7:0] serial_data_buffer, // received byte
   input wire asp_pkg::asp_status_t status // flags
);
   // timing checks only trust the one-tick-per-clock rates
   logic fast;
   assign fast = ctrl.double_rate && (ctrl.mode == asp_pkg::MODE_9FIX
      || (ctrl.mode[0] && timer_overflow));
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_tdone_hold;
      status.transmit_done_flag && !transmit_done_clear |=> status.transmit_done_flag;
   endproperty
   a_tdone_hold:
      assert property (p_tdone_hold) else $error("transmit flag dropped");
   property p_rdone_hold;
      status.receive_done_flag && !receive_done_clear |=> status.receive_done_flag;
   endproperty
   a_rdone_hold:
      assert property (p_rdone_hold) else $error("receive flag dropped");
   property p_tdone_stop;
      $rose(status.transmit_done_flag) |-> txd;
   endproperty
   a_tdone_stop:
      assert property (p_tdone_stop) else $error("transmit flag not at stop bit");
   property p_buf_keep;
      !$rose(status.receive_done_flag) |-> $stable(serial_data_buffer);
   endproperty
   a_buf_keep:
      assert property (p_buf_keep) else $error("buffer loaded without flag");
   property p_nine_keep;
      !$rose(status.receive_done_flag) |-> $stable(status.received_ninth_bit);
   endproperty
   a_nine_keep:
      assert property (p_nine_keep) else $error("ninth bit loaded without flag");
   property p_rx_off;
      !$past(ctrl.rx_enable) |-> !$rose(status.receive_done_flag);
   endproperty
   a_rx_off:
      assert property (p_rx_off) else $error("frame taken while disabled");
   property p_tx_start;
      buf_write && fast && ctrl.mode != 2'h0 |-> ##[1:18] !txd;
   endproperty
   a_tx_start:
      assert property (p_tx_start) else $error("start bit late");
   property p_tdone_m1;
      buf_write && fast && ctrl.mode == asp_pkg::MODE_8BIT && !status.transmit_done_flag
         |-> ##[144:162] $rose(status.transmit_done_flag);
   endproperty
   a_tdone_m1:
      assert property (p_tdone_m1) else $error("8-bit transmit flag mistimed");
   property p_tdone_m23;
      buf_write && fast && ctrl.mode[1] && !status.transmit_done_flag
         |-> ##[160:178] $rose(status.transmit_done_flag);
   endproperty
   a_tdone_m23:
      assert property (p_tdone_m23) else $error("9-bit transmit flag mistimed");
endmodule
bind asp_uart asp_uart_checker chk_i (.clk, .rst_n, .ctrl, .timer_overflow, .buf_write,
   .buf_write_data, .transmit_done_clear, .receive_done_clear, .rxd, .txd,
   .serial_data_buffer, .status);

// ===== dv/asp_uart_bench.sv
// self-checking bench for the asynchronous serial port
`timescale 1ns/1ps
module asp_uart_bench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   asp_pkg::asp_ctrl_t ctrl = '0;
   logic timer_overflow = 1'b1;
   logic slow_tmr = 1'b0;
   logic buf_write = 1'b0;
   logic [7:0] buf_write_data = 8'h00;
   logic transmit_done_clear = 1'b0;
   logic receive_done_clear = 1'b0;
   logic rxd;
   logic txd;
   logic [7:0] serial_data_buffer;
   asp_pkg::asp_status_t status;
   int n_fail = 0;
   int n_checks = 0;
   always #5 clk = ~clk;
   // overflow every clock, or every second clock for the slow rate run
   always @(posedge clk) #1 timer_overflow = slow_tmr ? ~timer_overflow : 1'b1;
   asp_uart dut (.clk, .rst_n, .ctrl, .timer_overflow, .buf_write, .buf_write_data,
      .transmit_done_clear, .receive_done_clear, .rxd, .txd, .serial_data_buffer, .status);
   asp_far_end far (.clk, .txd, .rxd);
   // *****************
   // helpers
   // *****************
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [10:0] got, input logic [10:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic clear_flags();
      transmit_done_clear = 1'b1;
      receive_done_clear = 1'b1;
      @(posedge clk);
      #1;
      transmit_done_clear = 1'b0;
      receive_done_clear = 1'b0;
   endtask
   // one frame out; the ninth bit is flipped after the write to show it was latched
   task automatic t_tx(input logic [1:0] md, input logic dr, input logic [7:0] d,
         input logic nb, input int bt);
      logic [10:0] got;
      bit ok;
      ctrl = '{mode: md, double_rate: dr, multiprocessor_filter: 1'b0, rx_enable: 1'b1,
         transmit_ninth_bit: nb};
      clear_flags();
      buf_write = 1'b1;
      buf_write_data = d;
      @(posedge clk);
      #1;
      buf_write = 1'b0;
      ctrl.transmit_ninth_bit = ~nb;
      far.recv(got, md[1] ? 11 : 10, bt, ok);
      chk("tx frame", got, md[1] ? {1'b1, nb, d, 1'b0} : {2'b01, d, 1'b0});
      chk("tx start", 11'(ok), 11'h001);
      chk("tx done", 11'(status.transmit_done_flag), 11'h001);
      repeat (bt) @(posedge clk);
      #1;
   endtask
   // shift-register mode is not served: a write must leave the line and flag alone
   task automatic t_mode0();
      int lows;
      ctrl = '0;
      clear_flags();
      buf_write = 1'b1;
      buf_write_data = 8'h3C;
      @(posedge clk);
      #1;
      buf_write = 1'b0;
      lows = 0;
      repeat (80) begin
         @(posedge clk);
         #1;
         lows += (txd !== 1'b1);
      end
      chk("mode0 line", 11'(lows), 11'h000);
      chk("mode0 flag", 11'(status.transmit_done_flag), 11'h000);
   endtask
   // one frame in; gl adds a short false start first
   task automatic t_rx(input logic [1:0] md, input logic flt, input logic en, input logic gl,
         input logic [7:0] d, input logic nb, input logic acc);
      logic [7:0] old_b;
      logic old_n;
      logic old_f;
      old_b = serial_data_buffer;
      old_n = status.received_ninth_bit;
      old_f = status.receive_done_flag;
      ctrl = '{mode: md, double_rate: 1'b1, multiprocessor_filter: flt, rx_enable: en,
         transmit_ninth_bit: 1'b0};
      if (gl) begin
         far.send(11'h7FE, 5, 4);
      end
      far.send({1'b1, nb, d, 1'b0}, md[1] ? 11 : 10, 16);
      chk("rx flag", 11'(status.receive_done_flag), 11'(acc | old_f));
      chk("rx byte", 11'(serial_data_buffer), 11'(acc ? d : old_b));
      chk("rx ninth", 11'(status.received_ninth_bit), 11'(acc ? nb : old_n));
   endtask
   // *****************
   // main sequence
   // *****************
   initial begin
      repeat (16) @(posedge clk);
      #1 rst_n = 1'b1;
      chk("idle line", 11'(txd), 11'h001);
      chk("idle flags", 11'(status), 11'h000);
      chk("idle buffer", 11'(serial_data_buffer), 11'h000);
      t_tx(asp_pkg::MODE_8BIT, 1'b1, 8'hA5, 1'b0, 16);
      t_tx(asp_pkg::MODE_9FIX, 1'b1, 8'h3C, 1'b1, 16);
      t_tx(asp_pkg::MODE_9VAR, 1'b1, 8'h81, 1'b0, 16);
      t_tx(asp_pkg::MODE_9FIX, 1'b0, 8'h5A, 1'b0, 32);
      slow_tmr = 1'b1;
      t_tx(asp_pkg::MODE_8BIT, 1'b0, 8'hC3, 1'b1, 64);
      slow_tmr = 1'b0;
      t_mode0();
      clear_flags();
      t_rx(asp_pkg::MODE_8BIT, 1'b0, 1'b1, 1'b0, 8'h96, 1'b1, 1'b1);
      t_rx(asp_pkg::MODE_9FIX, 1'b0, 1'b1, 1'b0, 8'h4B, 1'b0, 1'b0);
      clear_flags();
      t_rx(asp_pkg::MODE_9VAR, 1'b1, 1'b1, 1'b0, 8'h11, 1'b0, 1'b0);
      t_rx(asp_pkg::MODE_9VAR, 1'b1, 1'b1, 1'b0, 8'hE7, 1'b1, 1'b1);
      clear_flags();
      t_rx(asp_pkg::MODE_8BIT, 1'b1, 1'b1, 1'b0, 8'h5D, 1'b0, 1'b0);
      t_rx(asp_pkg::MODE_9FIX, 1'b0, 1'b1, 1'b1, 8'h2D, 1'b0, 1'b1);
      clear_flags();
      t_rx(asp_pkg::MODE_9FIX, 1'b0, 1'b0, 1'b0, 8'h77, 1'b1, 1'b0);
      t_rx(asp_pkg::MODE_9FIX, 1'b0, 1'b1, 1'b0, 8'h0F, 1'b1, 1'b1);
      end_of_test();
   end
   // watchdog: the whole sequence needs well under ten thousand clocks
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      end_of_test();
   end
endmodule
